/* File: core/asp_pkg.sv */
// constants, types and state records of the adc serial pin and calibration block
package asp_pkg;

  // ==========================================================
  // clocking and timing
  localparam int unsigned SYS_CLK_HZ     = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned MASTER_HZ_STD  = 4_000_000;
  localparam int unsigned MASTER_HZ_LP   = 1_800_000;
  localparam int unsigned MASTER_DIV_STD = SYS_CLK_HZ / MASTER_HZ_STD;
  localparam int unsigned MASTER_DIV_LP  = SYS_CLK_HZ / MASTER_HZ_LP;
  localparam int unsigned CAL_TICKS_DEF  = 1000;  // master ticks per calibration
  localparam int unsigned SCLK_HALF_NS   = 40;    // least half period of a self clock
  localparam int unsigned SCLK_HALF_CYC  = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  HALF_LAST      = 4'(SCLK_HALF_CYC - 1);

  // ==========================================================
  // serial word layout
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned DATA_W   = 14;
  localparam int unsigned ADDR_LSB = 14;
  localparam logic [3:0]  BIT_LAST = 4'(WORD_W - 1);
  localparam logic [1:0]  WA_NONE  = 2'h0;
  localparam logic [1:0]  WA_TEST  = 2'h1;
  localparam logic [1:0]  WA_CAL   = 2'h2;
  localparam logic [1:0]  WA_CTRL  = 2'h3;

  // ==========================================================
  // serial modes, {sel_b, sel_a}; the upper bit picks external clocking
  localparam logic [1:0]  MODE_SELF_IO = 2'h0;
  localparam logic [1:0]  MODE_SELF_IN = 2'h1;
  localparam logic [1:0]  MODE_EXT_CS  = 2'h2;
  localparam logic [1:0]  MODE_EXT_FS  = 2'h3;
  localparam int unsigned MODE_EXT_BIT = 1;

  // ==========================================================
  // apb register map, byte addresses
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_TX    = 8'h04;
  localparam logic [7:0]  OFS_STAT  = 8'h08;
  localparam logic [7:0]  OFS_RX    = 8'h0C;
  localparam logic [7:0]  OFS_WCTRL = 8'h10;
  localparam logic [7:0]  OFS_WTEST = 8'h14;
  localparam logic [7:0]  OFS_WCAL  = 8'h18;
  localparam int unsigned CTRL_DIN_DRV  = 0;
  localparam int unsigned CTRL_START    = 1;
  localparam int unsigned STAT_BUSY     = 0;
  localparam int unsigned STAT_FRAME    = 1;
  localparam int unsigned STAT_MODE_LSB = 2;
  localparam int unsigned STAT_POL      = 4;
  localparam int unsigned STAT_CAL_N    = 5;

  // ==========================================================
  // self clock frame sequencer
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_LEAD  = 5'h02,
    ST_ACT   = 5'h04,
    ST_REST  = 5'h08,
    ST_FLUSH = 5'h10
  } asp_fsm_t;

  // state of the system clock side
  typedef struct packed {
    logic              cal_s1;
    logic              cal_s2;
    logic              cal_s3;
    logic [1:0]        mode_s1;
    logic [1:0]        mode_s2;
    logic              pol_s1;
    logic              pol_s2;
    logic              tog_s1;
    logic              tog_s2;
    logic              tog_s3;
    logic [7:0]        div_cnt;
    logic              tick;
    logic [19:0]       cal_cnt;
    logic              busy;
    asp_fsm_t          st;
    logic [3:0]        half_cnt;
    logic [3:0]        bit_cnt;
    logic              sclk_o;
    logic              sclk_oe;
    logic              sync_o;
    logic              sync_oe;
    logic              din_oe;
    logic              din_drv;
    logic [WORD_W-1:0] tx_pend;
    logic [WORD_W-1:0] tx_live;
    logic [WORD_W-1:0] rx_last;
    logic [DATA_W-1:0] wctrl;
    logic [DATA_W-1:0] wtest;
    logic [DATA_W-1:0] wcal;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } asp_mst_t;

  // state of the shift clock side
  typedef struct packed {
    logic [WORD_W-1:0] shreg;
    logic [3:0]        bit_cnt;
    logic [WORD_W-1:0] rx_word;
    logic              rx_tog;
  } asp_lst_t;

endpackage

/* File: core/asp_serial_cal.sv */
// serial port pins and calibration trigger of a sampling adc, with apb access
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// ==========================================================
// Contract
// - calibration logic held reset while trigger low
// - trigger rising edge starts a calibration
// - trigger activity overrides the serial side but not apb access; it ends self frames and drops received words, external shifting goes on
// - one 16-bit word shifted out per transfer
// - mode makes data input pure input or bidirectional
// - self modes drive shift clock, external accept it
// - clock source idles at polarity pin level
// - frame select is low input or driven output
// - timing derived from nominal master clock rate
// - polarity one idles high, zero idles low
// - busy rises on trigger, holds till done
// - two top bits address, latch after sixteen
module asp_serial_cal #(
  parameter int unsigned P_CAL_TICKS  = asp_pkg::CAL_TICKS_DEF,
  parameter bit          P_LOW_POWER  = 1'b0
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_SCLK,
  output logic             O_SCLK_O,
  output logic             O_SCLK_OE,
  input  wire logic        I_SYNC,
  output logic             O_SYNC_O,
  output logic             O_SYNC_OE,
  input  wire logic        I_DIN,
  output logic             O_DIN_O,
  output logic             O_DIN_OE,
  output logic             O_DOUT,
  input  wire logic        I_CAL_N,
  input  wire logic        I_SERIAL_MODE_SEL_A,
  input  wire logic        I_SERIAL_MODE_SEL_B,
  input  wire logic        I_POLARITY,
  output logic             O_BUSY,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR
);

  // master tick divider and calibration length
  localparam logic [7:0]  DIV_LAST = 8'((P_LOW_POWER ? asp_pkg::MASTER_DIV_LP
                                                     : asp_pkg::MASTER_DIV_STD) - 1);
  localparam logic [19:0] CAL_LAST = 20'(P_CAL_TICKS - 1);

  asp_pkg::asp_mst_t q;
  asp_pkg::asp_mst_t d;
  asp_pkg::asp_lst_t lq;
  asp_pkg::asp_lst_t ld;

  logic        cal_lo;
  logic        cal_rise;
  logic        abort;
  logic        self_clk;
  logic        rx_ev;
  logic        acc;
  logic        start;
  logic        hit;
  logic [31:0] rdata;

  // ==========================================================
  // system clock side
  // one process computes every next value of the system side record
  always_comb begin
    d        = q;
    start    = 1'b0;
    hit      = 1'b1;
    rdata    = 32'h0000_0000;
    // trigger, mode and polarity pins pass two flops before any logic
    d.cal_s1  = I_CAL_N;
    d.cal_s2  = q.cal_s1;
    d.cal_s3  = q.cal_s2;
    d.mode_s1 = {I_SERIAL_MODE_SEL_B, I_SERIAL_MODE_SEL_A};
    d.mode_s2 = q.mode_s1;
    d.pol_s1  = I_POLARITY;
    d.pol_s2  = q.pol_s1;
    d.tog_s1  = lq.rx_tog;
    d.tog_s2  = q.tog_s1;
    d.tog_s3  = q.tog_s2;
    cal_lo    = !q.cal_s2;
    cal_rise  = q.cal_s2 && !q.cal_s3;
    abort     = cal_lo || cal_rise;
    self_clk  = !q.mode_s2[asp_pkg::MODE_EXT_BIT];
    rx_ev     = q.tog_s2 ^ q.tog_s3;
    acc       = I_PSEL && I_PENABLE;

    // master clock tick at the nominal converter clock rate
    d.tick = 1'b0;
    if (q.div_cnt == DIV_LAST) begin
      d.div_cnt = 8'h00;
      d.tick    = 1'b1;
    end else begin
      d.div_cnt = q.div_cnt + 8'h01;
    end

    // calibration: low level clears, rising edge starts, ticks time it
    if (cal_lo) begin
      d.busy    = 1'b0;
      d.cal_cnt = 20'h0_0000;
    end else if (cal_rise) begin
      d.busy    = 1'b1;
      d.cal_cnt = CAL_LAST;
    end else if (q.busy && q.tick) begin
      if (q.cal_cnt == 20'h0_0000) begin
        d.busy = 1'b0;
      end else begin
        d.cal_cnt = q.cal_cnt - 20'h0_0001;
      end
    end

    // pin directions follow the mode pins; data input drive also needs din_drv set
    d.sclk_oe = self_clk;
    d.sync_oe = self_clk;
    d.din_oe  = (q.mode_s2 == asp_pkg::MODE_SELF_IO) && q.din_drv;

    // apb: pready rises one cycle into the access phase, writes land on it
    d.pready  = acc && !q.pready;
    d.pslverr = 1'b0;
    case (I_PADDR)
      asp_pkg::OFS_CTRL: begin
        rdata[asp_pkg::CTRL_DIN_DRV] = q.din_drv;
      end
      asp_pkg::OFS_TX: begin
        rdata[asp_pkg::WORD_W-1:0] = q.tx_pend;
      end
      asp_pkg::OFS_STAT: begin
        rdata[asp_pkg::STAT_BUSY]                          = q.busy;
        rdata[asp_pkg::STAT_FRAME]                         = (q.st != asp_pkg::ST_IDLE);
        rdata[asp_pkg::STAT_MODE_LSB+1:asp_pkg::STAT_MODE_LSB] = q.mode_s2;
        rdata[asp_pkg::STAT_POL]                           = q.pol_s2;
        rdata[asp_pkg::STAT_CAL_N]                         = q.cal_s2;
      end
      asp_pkg::OFS_RX: begin
        rdata[asp_pkg::WORD_W-1:0] = q.rx_last;
      end
      asp_pkg::OFS_WCTRL: begin
        rdata[asp_pkg::DATA_W-1:0] = q.wctrl;
      end
      asp_pkg::OFS_WTEST: begin
        rdata[asp_pkg::DATA_W-1:0] = q.wtest;
      end
      asp_pkg::OFS_WCAL: begin
        rdata[asp_pkg::DATA_W-1:0] = q.wcal;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (acc && !q.pready) begin
      d.prdata  = rdata;
      d.pslverr = !hit;
    end
    if (acc && q.pready && I_PWRITE) begin
      if (I_PADDR == asp_pkg::OFS_CTRL) begin
        d.din_drv = I_PWDATA[asp_pkg::CTRL_DIN_DRV];
        start     = I_PWDATA[asp_pkg::CTRL_START];
      end else if (I_PADDR == asp_pkg::OFS_TX) begin
        d.tx_pend = I_PWDATA[asp_pkg::WORD_W-1:0];
      end
    end

    // finished word: refresh the outgoing word, decode the incoming one
    if (rx_ev) begin
      d.tx_live = q.tx_pend;
      // words that end during calibration are dropped
      if (!cal_lo && !q.busy) begin
        d.rx_last = lq.rx_word;
        case (lq.rx_word[asp_pkg::WORD_W-1:asp_pkg::ADDR_LSB])
          asp_pkg::WA_TEST: d.wtest = lq.rx_word[asp_pkg::DATA_W-1:0];
          asp_pkg::WA_CAL:  d.wcal  = lq.rx_word[asp_pkg::DATA_W-1:0];
          asp_pkg::WA_CTRL: d.wctrl = lq.rx_word[asp_pkg::DATA_W-1:0];
          default:          d.wctrl = q.wctrl;
        endcase
      end
    end

    // self clock sequencer; active level is the inverse of the idle level
    case (q.st)
      asp_pkg::ST_IDLE: begin
        d.sclk_o = q.pol_s2;
        d.sync_o = 1'b1;
        if (start && self_clk && !q.busy && !abort) begin
          d.st       = asp_pkg::ST_LEAD;
          d.sync_o   = 1'b0;
          d.half_cnt = asp_pkg::HALF_LAST;
          d.bit_cnt  = 4'h0;
        end
      end
      asp_pkg::ST_LEAD, asp_pkg::ST_ACT, asp_pkg::ST_REST: begin
        if (abort) begin
          // a pulse with select high lets the shifter forget a broken word
          d.st       = asp_pkg::ST_FLUSH;
          d.sync_o   = 1'b1;
          d.sclk_o   = q.pol_s2;
          d.half_cnt = asp_pkg::HALF_LAST;
          d.bit_cnt  = 4'h0;
        end else if (q.half_cnt != 4'h0) begin
          d.half_cnt = q.half_cnt - 4'h1;
        end else begin
          d.half_cnt = asp_pkg::HALF_LAST;
          if (q.st == asp_pkg::ST_ACT) begin
            d.st     = asp_pkg::ST_REST;
            d.sclk_o = q.pol_s2;
          end else if (q.st == asp_pkg::ST_REST && q.bit_cnt == asp_pkg::BIT_LAST) begin
            d.st     = asp_pkg::ST_IDLE;
            d.sync_o = 1'b1;
          end else begin
            d.st      = asp_pkg::ST_ACT;
            d.sclk_o  = !q.pol_s2;
            d.bit_cnt = (q.st == asp_pkg::ST_REST) ? q.bit_cnt + 4'h1 : q.bit_cnt;
          end
        end
      end
      asp_pkg::ST_FLUSH: begin
        d.sync_o = 1'b1;
        if (q.half_cnt != 4'h0) begin
          d.half_cnt = q.half_cnt - 4'h1;
        end else if (q.bit_cnt == 4'h0) begin
          d.half_cnt = asp_pkg::HALF_LAST;
          d.bit_cnt  = 4'h1;
          d.sclk_o   = !q.pol_s2;
        end else begin
          d.st     = asp_pkg::ST_IDLE;
          d.sclk_o = q.pol_s2;
        end
      end
      default: begin
        d.st = asp_pkg::ST_IDLE;
      end
    endcase
  end

  // system side register; synchronisers start at the quiet pin levels
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      q         <= '0;
      q.st      <= asp_pkg::ST_IDLE;
      q.sync_o  <= 1'b1;
      q.cal_s1  <= 1'b1;
      q.cal_s2  <= 1'b1;
      q.cal_s3  <= 1'b1;
      q.mode_s1 <= asp_pkg::MODE_EXT_FS;
      q.mode_s2 <= asp_pkg::MODE_EXT_FS;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // shift clock side
  // both ends sample on the rising edge; out data changes just after it
  always_comb begin
    ld = lq;
    if (I_SYNC) begin
      ld.bit_cnt = 4'h0;
    end else begin
      ld.bit_cnt = lq.bit_cnt + 4'h1;
      if (lq.bit_cnt == asp_pkg::BIT_LAST) begin
        // whole word in: hand it over, preload the next outgoing word
        ld.rx_word = {lq.shreg[asp_pkg::WORD_W-2:0], I_DIN};
        ld.rx_tog  = !lq.rx_tog;
        ld.shreg   = q.tx_live;
      end else begin
        ld.shreg = {lq.shreg[asp_pkg::WORD_W-2:0], I_DIN};
      end
    end
  end

  // the shift clock may stop between frames; nothing here waits for it
  always_ff @(posedge I_SCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // ==========================================================
  // outputs, each straight from a flop
  assign O_SCLK_O  = q.sclk_o;
  assign O_SCLK_OE = q.sclk_oe;
  assign O_SYNC_O  = q.sync_o;
  assign O_SYNC_OE = q.sync_oe;
  assign O_DIN_O   = lq.shreg[asp_pkg::WORD_W-1];
  assign O_DIN_OE  = q.din_oe;
  assign O_DOUT    = lq.shreg[asp_pkg::WORD_W-1];
  assign O_BUSY    = q.busy;
  assign O_PRDATA  = q.prdata;
  assign O_PREADY  = q.pready;
  assign O_PSLVERR = q.pslverr;

  // ==========================================================
  // checks
  // helper: active-level shift clock pulses issued in the current self frame
  logic [4:0] a_pulses_q;
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      a_pulses_q <= 5'h00;
    end else if (q.st == asp_pkg::ST_IDLE) begin
      a_pulses_q <= 5'h00;
    end else if (d.st == asp_pkg::ST_ACT && q.st != asp_pkg::ST_ACT) begin
      a_pulses_q <= a_pulses_q + 5'h01;
    end
  end

  sequence s_frame_end;
    q.st == asp_pkg::ST_REST && d.st == asp_pkg::ST_IDLE;
  endsequence

  sequence s_in_frame;
    q.st == asp_pkg::ST_LEAD || q.st == asp_pkg::ST_ACT || q.st == asp_pkg::ST_REST;
  endsequence

  a_cal_low_reset: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    !q.cal_s2 |=> !O_BUSY && q.cal_cnt == 20'h0_0000)
    else $error("calibration logic not held in reset");
  a_cal_rise_busy: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    q.cal_s2 && !q.cal_s3 |=> O_BUSY && q.cal_cnt == CAL_LAST)
    else $error("calibration did not start on rising trigger");
  a_busy_holds: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    O_BUSY && q.cal_cnt != 20'h0_0000 && q.cal_s2 |=> O_BUSY)
    else $error("busy dropped before calibration end");
  a_abort_frame: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    s_in_frame ##0 !q.cal_s2 |=> q.st == asp_pkg::ST_FLUSH && O_SYNC_O)
    else $error("calibration trigger did not abort frame");
  a_frame_pulses: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    s_frame_end |-> a_pulses_q == 5'(asp_pkg::WORD_W))
    else $error("self clock frame without sixteen pulses");
  a_pin_dirs: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    1'b1 |=> O_SCLK_OE == !$past(q.mode_s2[asp_pkg::MODE_EXT_BIT]) && O_SYNC_OE == O_SCLK_OE)
    else $error("clock or select direction does not follow mode");
  a_din_dir: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    O_DIN_OE |-> $past(q.mode_s2) == asp_pkg::MODE_SELF_IO)
    else $error("data input driven outside bidirectional mode");
  a_idle_level: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    q.st == asp_pkg::ST_IDLE && $past(q.st) == asp_pkg::ST_IDLE && $stable(q.pol_s2)
    |-> O_SCLK_O == q.pol_s2)
    else $error("shift clock idle level differs from polarity");
  a_tick_period: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    q.tick |=> !q.tick [*8])
    else $error("master tick too frequent");
  a_rx_ctrl: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (q.tog_s2 ^ q.tog_s3) && q.cal_s2 && !q.busy
    && lq.rx_word[asp_pkg::WORD_W-1:asp_pkg::ADDR_LSB] == asp_pkg::WA_CTRL
    |=> q.wctrl == $past(lq.rx_word[asp_pkg::DATA_W-1:0]))
    else $error("control word not latched after full word");
  a_word_end: assert property (@(posedge I_SCLK) disable iff (!I_RSTN)
    !I_SYNC && lq.bit_cnt == asp_pkg::BIT_LAST |=> lq.rx_tog != $past(lq.rx_tog))
    else $error("sixteenth bit did not hand over word");

endmodule

/* File: tb/asp_host.sv */
// behavioural host serial port facing the adc serial pins
`timescale 1ns/1ps
module asp_host (
  input  wire logic i_sclk,
  input  wire logic i_sync,
  input  wire logic i_dout,
  input  wire logic i_pol,
  output logic      o_sclk,
  output logic      o_sync,
  output logic      o_din
);
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  int          nbits;
  logic        run;
  logic        clk_v;
  // ==========================================================
  // clock stands at the polarity level outside frames
  assign o_sclk = run ? clk_v : i_pol;
  initial begin
    run = 0;
    clk_v = 0;
    o_sync = 1;
    o_din = 0;
    tx_word = 16'h0000;
    rx_word = 16'h0000;
    nbits = 0;
  end
  // ==========================================================
  // take dout at each rising edge, then present the next din bit
  always @(posedge i_sclk) begin
    if (i_sync === 1'b0) begin
      rx_word = {rx_word[14:0], i_dout};
      nbits = nbits + 1;
      #1 o_din = (nbits < 16) ? tx_word[15 - nbits] : ~o_din;
    end
  end
  // msb goes out first, ready well before the first edge
  always @(negedge i_sync) begin
    nbits = 0;
    o_din = tx_word[15];
  end
  // one externally clocked 16-bit frame, 15 ns bit period
  task frame();
    o_sync = 0;
    #7.5;
    run = 1;
    repeat (16) begin
      clk_v = 0;
      #7.5;
      clk_v = 1;
      #7.5;
    end
    run = 0;
    #7.5;
    o_sync = 1;
    o_din = ~o_din;  // released line must not keep its last value
    #30;
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench of the serial pin and calibration block
`timescale 1ns/1ps
module testbench;
  logic        clk, rstn, cal_n, sel_a, sel_b, pol;
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, busy, dout;
  logic        sclk_o, sclk_oe, sync_o, sync_oe, din_o, din_oe;
  logic        sclk_h, sync_h, din_h;
  wire         sclk_w = sclk_oe ? sclk_o : sclk_h;
  wire         sync_w = sync_oe ? sync_o : sync_h;
  wire         din_w  = din_oe ? din_o : din_h;
  int          mismatches, checks_done, cycles;
  logic [33:0] expq[$];
  logic [33:0] e;
  logic [15:0] word_a, word_b, last_rx;
  logic [13:0] ew[4];
  logic [7:0]  ofs[4];
  asp_serial_cal #(.P_CAL_TICKS(4), .P_LOW_POWER(1'b0)) uut (
    .I_MCLK(clk), .I_RSTN(rstn), .I_SCLK(sclk_w), .O_SCLK_O(sclk_o), .O_SCLK_OE(sclk_oe),
    .I_SYNC(sync_w), .O_SYNC_O(sync_o), .O_SYNC_OE(sync_oe), .I_DIN(din_w), .O_DIN_O(din_o),
    .O_DIN_OE(din_oe), .O_DOUT(dout), .I_CAL_N(cal_n), .I_SERIAL_MODE_SEL_A(sel_a),
    .I_SERIAL_MODE_SEL_B(sel_b), .I_POLARITY(pol), .O_BUSY(busy), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));
  asp_host host (.i_sclk(sclk_w), .i_sync(sync_w), .i_dout(dout), .i_pol(pol),
    .o_sclk(sclk_h), .o_sync(sync_h), .o_din(din_h));
  // ==========================================================
  // clock, timeout and comparison helpers
  always #2.5 clk = ~clk;
  task complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // a hang ends the run as a failure after 40000 clock cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      complete_run();
    end
  end
  // ==========================================================
  // apb master: request held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h00000000;
    expq.push_back({w, err, d});
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  // watcher takes the oldest note when an answer appears
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      e = expq.pop_front();
      if (!e[33]) chk(prdata, e[31:0]);
      chk(pslverr, e[32]);
    end
  end
  task set_mode(input logic [1:0] m, input logic p);
    @(posedge clk);
    sel_b <= m[1];
    sel_a <= m[0];
    pol <= p;
    repeat (6) @(posedge clk);
  endtask
  task wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    clk = 0; rstn = 0; cal_n = 1; sel_a = 0; sel_b = 1; pol = 0;
    psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h00000000;
    mismatches = 0; checks_done = 0; cycles = 0; last_rx = 16'h0000;
    ew = '{default: 14'h0000};
    ofs = '{8'h00, asp_pkg::OFS_WTEST, asp_pkg::OFS_WCAL, asp_pkg::OFS_WCTRL};
    wait_cyc(10);
    chk(sync_o, 1'b1);
    chk(sclk_oe, 1'b0);
    chk(busy, 1'b0);
    wait_cyc(10);
    rstn <= 1;
    void'($urandom(18));
    // refused unmapped read, then an ignored status write
    apb(0, 8'h40, 32'h00000000, 1);
    apb(1, asp_pkg::OFS_STAT, 32'hFFFFFFFF, 0);
    // external modes: nothing driven, status shows pins
    for (int m = 2; m < 4; m++) for (int p = 0; p < 2; p++) begin
      set_mode(2'(m), 1'(p));
      chk({sclk_oe, sync_oe, din_oe}, 3'h0);
      apb(0, asp_pkg::OFS_STAT, 32'(32'h20 | (p << 4) | (m << 2)), 0);
    end
    // externally clocked writes to every address code
    word_a = 16'($urandom);
    apb(1, asp_pkg::OFS_TX, {16'h0000, word_a}, 0);
    for (int a = 0; a < 4; a++) begin
      host.tx_word = {2'(a), 14'($urandom)};
      host.frame();
      if (a != 0) ew[a] = host.tx_word[13:0];
      last_rx = host.tx_word;
      wait_cyc(10);
      chk(host.rx_word, (a >= 2) ? word_a : 16'h0000);
      chk(host.nbits, 16);
      apb(0, asp_pkg::OFS_RX, {16'h0000, last_rx}, 0);
      for (int r = 1; r < 4; r++) apb(0, ofs[r], {18'h0, ew[r]}, 0);
    end
    // calibration: low holds reset, rise starts, activity aborts
    cal_n <= 0;
    wait_cyc(5);
    chk(busy, 1'b0);
    host.tx_word = 16'($urandom);
    host.frame();
    wait_cyc(10);
    apb(0, asp_pkg::OFS_RX, {16'h0000, last_rx}, 0);
    cal_n <= 1;
    wait_cyc(5);
    chk(busy, 1'b1);
    host.tx_word = 16'($urandom);
    host.frame();
    wait_cyc(10);
    apb(0, asp_pkg::OFS_RX, {16'h0000, last_rx}, 0);
    cal_n <= 0;
    wait_cyc(4);
    chk(busy, 1'b0);
    cal_n <= 1;
    wait_cyc(140);
    chk(busy, 1'b1);
    wait_cyc(120);
    chk(busy, 1'b0);
    // self clock modes: device sources clock and frame at the set level
    for (int p = 0; p < 2; p++) begin
      set_mode(asp_pkg::MODE_SELF_IO, 1'(p));
      chk({sclk_oe, sclk_o, sync_oe, sync_o, din_oe}, {1'b1, 1'(p), 3'b110});
      apb(1, asp_pkg::OFS_CTRL, 32'h00000001, 0);
      wait_cyc(2);
      chk(din_oe, 1'b1);
      chk(din_o, word_a[15]);
      apb(1, asp_pkg::OFS_CTRL, 32'h00000000, 0);
    end
    set_mode(asp_pkg::MODE_SELF_IN, 1'b1);
    apb(1, asp_pkg::OFS_CTRL, 32'h00000001, 0);
    wait_cyc(2);
    chk(din_oe, 1'b0);
    word_b = 16'($urandom);
    host.tx_word = 16'($urandom);
    apb(1, asp_pkg::OFS_TX, {16'h0000, word_b}, 0);
    for (int f = 0; f < 3; f++) begin
      apb(1, asp_pkg::OFS_CTRL, 32'h00000002, 0);
      wait_cyc(320);
      chk(host.nbits, 16);
    end
    chk(host.rx_word, word_b);
    apb(0, asp_pkg::OFS_RX, {16'h0000, host.tx_word}, 0);
    // trigger in mid-frame ends the self frame
    apb(1, asp_pkg::OFS_CTRL, 32'h00000002, 0);
    wait_cyc(100);
    cal_n <= 0;
    wait_cyc(4);
    chk({sync_o, busy}, 2'b10);
    cal_n <= 1;
    wait_cyc(300);
    apb(0, asp_pkg::OFS_STAT, 32'h00000034, 0);
    complete_run();
  end
endmodule
